// *** verilog/ssc_channel.sv ***
// Multimode synchronous serial channel with AXI4-Lite register access.
// Assumes pins are synchronous to core_clk_in; open-drain pins are split
// into input, output and output enable, resolved outside.
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module ssc_channel import ssc_pkg::*; (
	input  wire logic        core_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	input  wire logic        serial_clock_pin_in,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe_out,
	input  wire logic        serial_in_pin_in,
	output logic             serial_out_pin_out,
	output logic             serial_out_pin_oe_out,
	input  wire logic        bus_data_pin_a_in,
	output logic             bus_data_pin_a_out,
	output logic             bus_data_pin_a_oe_out,
	input  wire logic        bus_data_pin_b_in,
	output logic             bus_data_pin_b_out,
	output logic             bus_data_pin_b_oe_out,
	input  wire logic        timer2_output_in,
	output logic             transfer_irq_out
);

	// ==========================================================
	// Registers and state
	logic [7:0]  shift_data;
	logic [7:0]  own_bus_address;
	logic [7:0]  mode_control_reg;
	logic [7:0]  bus_control_reg;
	logic [7:0]  irq_timing_reg;
	logic [3:0]  clk_sel;
	logic        out_latch;
	logic [3:0]  bit_cnt;
	logic        busy;
	logic        ack_phase;
	logic        ack_drive;
	logic        addr_phase;
	logic        transfer_done_flag;
	logic        sclk_int;
	logic [7:0]  div_cnt;
	logic        ext_q;
	logic        tmr_q;
	logic        data_q;
	logic        aw_hold;
	logic        w_hold;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_fire;
	logic        shift_wr;
	ssc_mode_e   mode;

	wire enable    = mode_control_reg[SSC_MODE_EN];
	wire is_bus    = (mode == SSC_M_BUS);
	wire use_int   = mode_control_reg[1];
	wire ack_en    = bus_control_reg[SSC_BUS_AUTO_ACK_ENABLE];
	wire nine_wait = irq_timing_reg[1] & irq_timing_reg[0];
	wire wup_all   = mode_control_reg[SSC_MODE_WUP] & irq_timing_reg[SSC_IRQT_SIC];
	wire wr_byte   = w_strb[0];

	// Mode decode from mode control bits 4:3
	always_comb begin
		if (!mode_control_reg[4])
			mode = SSC_M_3W;
		else if (!mode_control_reg[3])
			mode = SSC_M_BUS;
		else
			mode = SSC_M_2W;
	end

	// ==========================================================
	// Serial clock source selection
	wire div_tick = (div_cnt == 8'h00);
	wire int_clk  = mode_control_reg[0] ? sclk_int : (tmr_q | ~busy); // Idle high between words
	wire ext_clk  = use_int ? int_clk : serial_clock_pin_in;
	wire src_clk  = ext_clk;
	wire sck_rise = src_clk & ~ext_q;
	wire sck_fall = ~src_clk & ext_q;
	wire data_in  = (mode == SSC_M_3W) ? serial_in_pin_in :
		(mode_control_reg[2] ? bus_data_pin_a_in : bus_data_pin_b_in);
	wire msb_first = (mode != SSC_M_3W) | ~mode_control_reg[SSC_MODE_LSB];

	// Internal divider: main clock over 2^(clk_sel-6)
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			div_cnt  <= 8'h00;
			sclk_int <= 1'b1;
		end else if (busy && mode_control_reg[0]) begin
			if (div_tick) begin
				div_cnt  <= 8'((8'h01 << (clk_sel - SSC_RST_CLK + 4'h1)) - 8'h01);
				sclk_int <= ~sclk_int;
			end else begin
				div_cnt <= div_cnt - 8'h01;
			end
		end else begin
			div_cnt  <= 8'h00;
			sclk_int <= 1'b1;
		end
	end

	// Edge history of the selected clock, the timer output and the data line
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			ext_q  <= 1'b1;
			tmr_q  <= 1'b0;
			data_q <= 1'b1;
		end else begin
			ext_q  <= src_clk;
			tmr_q  <= timer2_output_in;
			data_q <= data_in;
		end
	end

	// ==========================================================
	// Start and stop condition detection, bus mode only
	wire cond_ok  = is_bus & enable & ext_clk & ext_q;
	wire start_ev = cond_ok & data_q & ~data_in;
	wire stop_ev  = cond_ok & ~data_q & data_in;

	// ==========================================================
	// Transfer engine: counter, shifter, acknowledge
	wire gated_rise = busy & sck_rise;
	wire gated_fall = busy & sck_fall;
	wire [3:0] last_cnt = (is_bus && nine_wait) ? SSC_NINE_CNT : SSC_WORD_CNT;
	wire word_end   = gated_rise & (bit_cnt == SSC_WORD_CNT - 4'h1);
	wire [7:0] rx_word = msb_first ? {shift_data[6:0], data_in} : {data_in, shift_data[7:1]};
	// Ninth clock carries no data bit: compare the finished word
	wire [7:0] cmp_word = (bit_cnt == SSC_WORD_CNT) ? shift_data : rx_word;
	wire cmp_mask = irq_timing_reg[SSC_IRQT_MASK];
	wire match_now = (cmp_word[7:1] == own_bus_address[7:1]) &
		(cmp_mask | (cmp_word[0] == own_bus_address[0]));

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			busy      <= 1'b0;
			bit_cnt   <= 4'h0;
			ack_phase <= 1'b0;
			addr_phase <= 1'b0;
		end else if (!enable) begin
			busy      <= 1'b0;
			bit_cnt   <= 4'h0;
			ack_phase <= 1'b0;
			addr_phase <= 1'b0;
		end else begin
			if (start_ev)
				addr_phase <= 1'b1;
			else if (word_end)
				addr_phase <= 1'b0;
			if (shift_wr && !busy) begin
				busy    <= 1'b1;
				bit_cnt <= 4'h0;
			end else if (gated_rise) begin
				bit_cnt <= bit_cnt + 4'h1;
				if (bit_cnt + 4'h1 == last_cnt) begin
					busy <= 1'b0;
				end
			end
			ack_phase <= busy && is_bus && (bit_cnt == SSC_WORD_CNT);
		end
	end

	// Shift register: written by software, shifted by the serial clock
	always_ff @(posedge core_clk_in) begin
		if (shift_wr && enable && !busy)
			shift_data <= w_data[7:0];
		else if (gated_rise && bit_cnt < SSC_WORD_CNT)
			shift_data <= rx_word;
	end

	// Own bus address, no reset value
	always_ff @(posedge core_clk_in) begin
		if (wr_fire && wr_byte && aw_addr == SSC_ADDR_OWN)
			own_bus_address <= w_data[7:0];
	end

	// Output level latch: loaded on falling edge, set or cleared by software
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in)
			out_latch <= 1'b1;
		else if (wr_fire && wr_byte && aw_addr == SSC_ADDR_BUS && w_data[SSC_BUS_STRT])
			out_latch <= 1'b0;
		else if (wr_fire && wr_byte && aw_addr == SSC_ADDR_BUS && w_data[SSC_BUS_RELT])
			out_latch <= 1'b1;
		else if (shift_wr && enable && !busy)
			out_latch <= msb_first ? w_data[7] : w_data[0];
		else if (gated_fall && bit_cnt < SSC_WORD_CNT)
			out_latch <= msb_first ? shift_data[7] : shift_data[0];
	end

	// Acknowledge drive: auto at ninth falling edge (nine-clock wait only) or software trigger
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in || !enable || !is_bus)
			ack_drive <= 1'b0;
		else if (gated_fall && bit_cnt == SSC_WORD_CNT && ack_en)
			ack_drive <= 1'b1;
		else if (sck_fall && bus_control_reg[SSC_BUS_SOFT_ACK_TRIGGER])
			ack_drive <= 1'b1;
		else if (gated_fall || (!busy && sck_fall && !bus_control_reg[SSC_BUS_SOFT_ACK_TRIGGER]))
			ack_drive <= 1'b0;
	end

	// ==========================================================
	// Completion flag and interrupt generation
	wire word_irq = word_end && !(is_bus && nine_wait);
	wire nine_irq = gated_rise && bit_cnt == SSC_WORD_CNT;
	wire any_end  = word_irq | nine_irq;
	wire irq_ev   = wup_all ? ((any_end && addr_phase && match_now) || stop_ev) : any_end;

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in)
			transfer_done_flag <= 1'b0;
		else if (irq_ev)
			transfer_done_flag <= 1'b1;
		else if (shift_wr)
			transfer_done_flag <= 1'b0;
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in)
			transfer_irq_out <= 1'b0;
		else
			transfer_irq_out <= irq_ev;
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			mode_control_reg <= SSC_RST_REG;
			irq_timing_reg   <= SSC_RST_REG;
			clk_sel          <= SSC_RST_CLK;
		end else begin
			if (wr_fire && wr_byte && aw_addr == SSC_ADDR_MODE) begin
				mode_control_reg[7]   <= w_data[7];
				mode_control_reg[5:0] <= w_data[5:0];
			end
			if (wr_fire && wr_byte && aw_addr == SSC_ADDR_IRQT)
				irq_timing_reg <= {2'h0, w_data[5:0]};
			if (wr_fire && wr_byte && aw_addr == SSC_ADDR_CLK)
				clk_sel <= w_data[3:0];
			if (!enable)
				mode_control_reg[SSC_MODE_MATCH] <= 1'b0;
			else if (any_end && (is_bus || mode == SSC_M_2W))
				mode_control_reg[SSC_MODE_MATCH] <= match_now;
		end
	end

	// Bus control: writable bits plus hardware status bits
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			bus_control_reg <= SSC_RST_REG;
		end else if (!enable) begin
			bus_control_reg <= {bus_control_reg[7], 1'b0, bus_control_reg[5], 5'h00};
		end else begin
			if (wr_fire && wr_byte && aw_addr == SSC_ADDR_BUS) begin
				bus_control_reg[SSC_BUS_BUS_BUSY_ENABLE] <= w_data[SSC_BUS_BUS_BUSY_ENABLE];
				bus_control_reg[SSC_BUS_AUTO_ACK_ENABLE] <= w_data[SSC_BUS_AUTO_ACK_ENABLE];
				bus_control_reg[SSC_BUS_SOFT_ACK_TRIGGER] <= w_data[SSC_BUS_SOFT_ACK_TRIGGER];
			end else if (shift_wr || (sck_fall && !busy)) begin
				bus_control_reg[SSC_BUS_SOFT_ACK_TRIGGER] <= 1'b0;
			end
			bus_control_reg[SSC_BUS_STRT] <= 1'b0;
			bus_control_reg[SSC_BUS_RELT] <= 1'b0;
			if (start_ev)
				bus_control_reg[SSC_BUS_STRD] <= 1'b1;
			else if (stop_ev || shift_wr)
				bus_control_reg[SSC_BUS_STRD] <= 1'b0;
			if (stop_ev)
				bus_control_reg[SSC_BUS_STPD] <= 1'b1;                   // set wins
			else if ((any_end && addr_phase && !match_now) || start_ev)
				bus_control_reg[SSC_BUS_STPD] <= 1'b0;
			if (is_bus && ack_phase && sck_rise && !data_in)
				bus_control_reg[SSC_BUS_ACKD] <= 1'b1;
			else if (shift_wr)
				bus_control_reg[SSC_BUS_ACKD] <= 1'b0;
		end
	end

	// ==========================================================
	// Pin drive; open-drain lines drive low only
	wire line_low = is_bus ? (~out_latch | ack_drive) : ~out_latch;
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			serial_clock_pin_out    <= 1'b1;
			serial_clock_pin_oe_out <= 1'b0;
			serial_out_pin_out      <= 1'b1;
			serial_out_pin_oe_out   <= 1'b0;
			bus_data_pin_a_out      <= 1'b0;
			bus_data_pin_a_oe_out   <= 1'b0;
			bus_data_pin_b_out      <= 1'b0;
			bus_data_pin_b_oe_out   <= 1'b0;
		end else begin
			serial_clock_pin_out    <= int_clk;
			serial_clock_pin_oe_out <= enable & use_int &
				((mode == SSC_M_3W) | ~int_clk);
			serial_out_pin_out      <= out_latch;
			serial_out_pin_oe_out   <= enable & (mode == SSC_M_3W);
			bus_data_pin_a_out      <= 1'b0;
			bus_data_pin_a_oe_out   <= enable & (mode != SSC_M_3W) & mode_control_reg[2] & line_low;
			bus_data_pin_b_out      <= 1'b0;
			bus_data_pin_b_oe_out   <= enable & (mode != SSC_M_3W) & ~mode_control_reg[2] & line_low;
		end
	end

	// ==========================================================
	// AXI4-Lite write channel: address and data in either order
	assign wr_fire  = aw_hold & w_hold & ~s_axi_bvalid_out;
	assign shift_wr = wr_fire & wr_byte & (aw_addr == SSC_ADDR_SHIFT);

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			aw_hold           <= 1'b0;
			w_hold            <= 1'b0;
			aw_addr           <= 8'h00;
			w_data            <= 32'h0;
			w_strb            <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= SSC_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_hold           <= 1'b1;
				aw_addr           <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_hold           <= 1'b1;
				w_data           <= s_axi_wdata_in;
				w_strb           <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (wr_fire) begin
				aw_hold          <= 1'b0;
				w_hold           <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= (aw_addr <= SSC_ADDR_CLK && aw_addr[1:0] == 2'h0) ?
					SSC_OKAY : SSC_SLVERR;
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out  <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out  <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel with address decode
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0;
			s_axi_rresp_out   <= SSC_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rresp_out   <= SSC_OKAY;
			if (s_axi_araddr_in == SSC_ADDR_SHIFT)
				s_axi_rdata_out <= {24'h0, shift_data};
			else if (s_axi_araddr_in == SSC_ADDR_OWN)
				s_axi_rdata_out <= {24'h0, own_bus_address};
			else if (s_axi_araddr_in == SSC_ADDR_MODE)
				s_axi_rdata_out <= {23'h0, transfer_done_flag, mode_control_reg};
			else if (s_axi_araddr_in == SSC_ADDR_BUS)
				s_axi_rdata_out <= {24'h0, bus_control_reg};
			else if (s_axi_araddr_in == SSC_ADDR_IRQT)
				s_axi_rdata_out <= {24'h0, irq_timing_reg};
			else if (s_axi_araddr_in == SSC_ADDR_CLK)
				s_axi_rdata_out <= {28'h0, clk_sel};
			else begin
				s_axi_rdata_out <= 32'h0;
				s_axi_rresp_out <= SSC_SLVERR;
			end
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out  <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end

endmodule

// *** verilog/ssc_pkg.sv ***
// Constants and register map of the multimode synchronous serial channel.
// Assumes an AXI4-Lite master with 32-bit data and one clock domain.

package ssc_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] SSC_ADDR_SHIFT = 8'h00;
	localparam logic [7:0] SSC_ADDR_OWN   = 8'h04;
	localparam logic [7:0] SSC_ADDR_MODE  = 8'h08;
	localparam logic [7:0] SSC_ADDR_BUS   = 8'h0c;
	localparam logic [7:0] SSC_ADDR_IRQT  = 8'h10;
	localparam logic [7:0] SSC_ADDR_CLK   = 8'h14;

	// ==========================================================
	// Mode control bit positions
	localparam int SSC_MODE_EN    = 7;
	localparam int SSC_MODE_MATCH = 6;
	localparam int SSC_MODE_WUP   = 5;
	localparam int SSC_MODE_LSB   = 2;

	// Bus control bit positions
	localparam int SSC_BUS_BUS_BUSY_ENABLE = 7;
	localparam int SSC_BUS_ACKD = 6;
	localparam int SSC_BUS_AUTO_ACK_ENABLE = 5;
	localparam int SSC_BUS_SOFT_ACK_TRIGGER = 4;
	localparam int SSC_BUS_STRD = 3;
	localparam int SSC_BUS_STPD = 2;
	localparam int SSC_BUS_STRT = 1;
	localparam int SSC_BUS_RELT = 0;

	// Interrupt timing bit positions
	localparam int SSC_IRQT_SIC  = 5;
	localparam int SSC_IRQT_MASK = 4;

	// ==========================================================
	// Reset values and counts
	localparam logic [7:0] SSC_RST_REG  = 8'h00;
	localparam logic [3:0] SSC_RST_CLK  = 4'h8;
	localparam logic [3:0] SSC_WORD_CNT = 4'h8;
	localparam logic [3:0] SSC_NINE_CNT = 4'h9;
	localparam logic [1:0] SSC_OKAY     = 2'h0;
	localparam logic [1:0] SSC_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		SSC_M_3W,
		SSC_M_2W,
		SSC_M_BUS
	} ssc_mode_e;

endpackage

// *** sim/ssc_channel_sva.sv ***
// Port checks for the serial channel.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module ssc_channel_sva import ssc_pkg::*; (
	input wire logic        core_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic        serial_clock_pin_in,
	input wire logic        serial_out_pin_oe_out,
	input wire logic        bus_data_pin_a_out,
	input wire logic        bus_data_pin_a_oe_out,
	input wire logic        transfer_irq_out
);
	// ==========
	// Serial side
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	a_irq_one_pulse: assert property (transfer_irq_out |=> !transfer_irq_out)
		else $error("irq pulse too long");
	a_irq_clk_idle: assert property (transfer_irq_out |-> serial_clock_pin_in)
		else $error("clock not idle at word end");
	a_line_pull_low: assert property (!bus_data_pin_a_out)
		else $error("open-drain data driven high");
	a_pins_exclusive: assert property (!(serial_out_pin_oe_out && bus_data_pin_a_oe_out))
		else $error("three-wire and shared line both driven");
	// ==========
	// Register bus
	a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
		&& s_axi_wready_out |-> ##[1:4] s_axi_bvalid_out)
		else $error("write response missing");
	a_bresp_held: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped");
	a_rdata_held: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped");
	a_upper_zero: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:9] == 23'h0)
		else $error("upper read bits set");
	a_resp_legal: assert property (s_axi_bvalid_out
		|-> s_axi_bresp_out == SSC_OKAY || s_axi_bresp_out == SSC_SLVERR)
		else $error("illegal write response");
	a_reset_idle: assert property ($fell(sys_rst_in) |-> s_axi_awready_out
		&& !s_axi_bvalid_out && !s_axi_rvalid_out && !transfer_irq_out)
		else $error("outputs not idle after reset");
endmodule

// *** sim/ssc_peer.sv ***
// Far-side serial device: shifts one word on the channel clock.
// Assumes pins sampled on the core clock; shared line pulled up.
`timescale 1ns/1ps

module ssc_peer (
	input  wire logic       core_clk_in,
	input  wire logic       load_in,
	input  wire logic [7:0] byte_in,
	input  wire logic       lsb_in,
	input  wire logic       sck_in,
	input  wire logic       line_in,
	output logic            si_out,
	output logic            sda_oe_out,
	output logic [7:0]      got_out
);
	logic [7:0] sh = 8'hff;
	logic [3:0] n = 4'h8;
	logic       sck_q = 1'b1;
	logic       idle_q = 1'b0;
	logic       bit_v;

	// ==========
	// Bit shown, released line outside frames
	assign bit_v = lsb_in ? sh[0] : sh[7];
	assign si_out = (n == 4'h8) ? idle_q : bit_v;
	assign sda_oe_out = (n != 4'h8) && !bit_v;

	// Load, capture on rise, shift on fall
	always @(posedge core_clk_in) begin
		sck_q <= sck_in;
		idle_q <= ~idle_q;
		if (load_in) begin
			sh <= byte_in;
			n <= 4'h0;
		end else if (n != 4'h8 && sck_in && !sck_q) begin
			got_out <= lsb_in ? {line_in, got_out[7:1]} : {got_out[6:0], line_in};
			n <= n + 4'h1;
		end else if (n != 4'h0 && n != 4'h8 && !sck_in && sck_q)
			sh <= lsb_in ? sh >> 1 : sh << 1;
	end
endmodule

// *** sim/ssc_channel_tb.sv ***
// Self-checking bench: registers, three-wire, two-wire and bus words.
// Assumes ssc_peer on the serial pins and the bound port checker.
`timescale 1ns/1ps

module ssc_channel_tb import ssc_pkg::*;;
	localparam logic [7:0] MS[6] = '{8'h82, 8'h83, 8'h87, 8'h9f, 8'h97, 8'h97};
	localparam logic [7:0] TS[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h13};
	localparam logic [7:0] RA[4] = '{SSC_ADDR_MODE, SSC_ADDR_BUS, SSC_ADDR_IRQT, SSC_ADDR_CLK};
	logic        clk, rst, awv, wv, bre, arv, rre, t2, pload, plsb;
	logic [7:0]  awa, ara, pbyte, cur_m;
	logic [31:0] wd, r;
	logic [1:0]  e;
	logic [15:0] seed;
	logic        sck_q;
	wire         awr, wrd, bv, arr, rv, sck_o, sck_oe, so, so_oe, irq, si, poe;
	wire         da_o, da_oe, db_o, db_oe;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [7:0]   pgot;
	wire         sda_a = !(da_oe || poe);
	wire         sda_b = !(db_oe || poe);
	wire         sck = sck_oe ? sck_o : 1'b1;
	wire         pline = cur_m[4] ? (sda_a & sda_b) : so;
	int          failures, total_checks, rises, irqs, r0, i0, cyc;

	ssc_channel u_dut (.core_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awa),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rre), .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_o),
		.serial_clock_pin_oe_out(sck_oe), .serial_in_pin_in(si), .serial_out_pin_out(so),
		.serial_out_pin_oe_out(so_oe), .bus_data_pin_a_in(sda_a), .bus_data_pin_a_out(da_o),
		.bus_data_pin_a_oe_out(da_oe), .bus_data_pin_b_in(sda_b), .bus_data_pin_b_out(db_o),
		.bus_data_pin_b_oe_out(db_oe), .timer2_output_in(t2), .transfer_irq_out(irq));
	ssc_peer u_peer (.core_clk_in(clk), .load_in(pload), .byte_in(pbyte), .lsb_in(plsb),
		.sck_in(sck), .line_in(pline), .si_out(si), .sda_oe_out(poe), .got_out(pgot));

	// ==========
	// Clocks and event counters
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Timer output toggles every eight core cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		t2 <= cyc[3];
		sck_q <= sck;
		if (sck && !sck_q) rises <= rises + 1;
		if (irq) irqs <= irqs + 1;
	end

	// ==========
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [7:0] exp_peer(input logic [7:0] m, d, p);
		return m[4] ? (d & p) : d;
	endfunction
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit pa = 1;
		bit pw = 1;
		int t;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		for (t = 0; t < 200 && (pa || pw || !bv); t++) begin
			@(posedge clk);
			if (pa && awr) awv <= 1'b0;
			if (awr) pa = 0;
			if (pw && wrd) wv <= 1'b0;
			if (wrd) pw = 0;
		end
		if (t == 200) failures++;
		bre <= 1'b1;
		@(posedge clk);
		e = bresp;
		bre <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		bit pa = 1;
		int t;
		ara <= a;
		arv <= 1'b1;
		for (t = 0; t < 200 && (pa || !rv); t++) begin
			@(posedge clk);
			if (pa && arr) arv <= 1'b0;
			if (arr) pa = 0;
		end
		if (t == 200) failures++;
		rre <= 1'b1;
		@(posedge clk);
		r = rdata;
		e = rresp;
		rre <= 1'b0;
	endtask
	// One word in the mode of table row i
	task automatic xfer(input int i);
		logic [7:0] m, d, p, x;
		m = MS[i];
		seed = lfsr(seed);
		d = seed[7:0];
		p = seed[15:8];
		x = m[4] ? (d & p) : p;
		wr(SSC_ADDR_MODE, 32'h0);
		wr(SSC_ADDR_IRQT, {24'h0, TS[i]});
		wr(SSC_ADDR_OWN, {24'h0, x ^ {7'h0, i > 3}});
		cur_m <= m;
		plsb <= m[2] & !m[4];
		pbyte <= p;
		pload <= 1'b1;
		wr(SSC_ADDR_MODE, {24'h0, m});
		pload <= 1'b0;
		r0 = rises;
		i0 = irqs;
		wr(SSC_ADDR_SHIFT, {24'h0, d});
		for (int n = 0; n < 3000 && irqs == i0; n++) @(posedge clk);
		repeat (4) @(posedge clk);
		chk("clocks", (TS[i][1:0] == 2'b11) ? 32'd9 : 32'd8, 32'(rises - r0));
		chk("peer", {24'h0, exp_peer(m, d, p)}, {24'h0, pgot});
		rd(SSC_ADDR_SHIFT);
		chk("shift", {24'h0, x}, r);
		rd(SSC_ADDR_MODE);
		chk("done", 32'h1, {31'h0, r[8]});
		if (m[4]) chk("match", {31'h0, i != 4}, {31'h0, r[6]});
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ==========
	// Main sequence
	initial begin
		{awv, wv, bre, arv, rre, pload, plsb} = '0;
		{awa, ara, pbyte, cur_m, wd} = '0;
		seed = 16'h86ad;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (RA[k]) begin
			rd(RA[k]);
			chk("reset", (k == 3) ? {28'h0, SSC_RST_CLK} : 32'h0, r);
		end
		rd(8'h18);
		chk("unmapped", {30'h0, SSC_SLVERR}, {30'h0, e});
		wr(8'h02, 32'h0);
		chk("unaligned", {30'h0, SSC_SLVERR}, {30'h0, e});
		wr(SSC_ADDR_MODE, 32'h03);
		r0 = rises;
		i0 = irqs;
		wr(SSC_ADDR_SHIFT, 32'h5a);
		repeat (100) @(posedge clk);
		chk("refused", 32'h0, 32'(rises - r0 + irqs - i0));
		repeat (2) for (int i = 0; i < 6; i++) xfer(i);
		wr(SSC_ADDR_BUS, 32'h01);
		repeat (3) @(posedge clk);
		chk("release", 32'h0, {31'h0, da_oe});
		wr(SSC_ADDR_BUS, 32'h02);
		repeat (3) @(posedge clk);
		chk("start", 32'h1, {31'h0, da_oe});
		rd(SSC_ADDR_BUS);
		chk("trigger", 32'h0, {31'h0, r[SSC_BUS_STRT]});
		chk("start seen", 32'h1, {31'h0, r[SSC_BUS_STRD]});
		conclude();
	end

	// Hang guard
	initial begin
		#2000000;
		failures++;
		conclude();
	end
endmodule

bind ssc_channel ssc_channel_sva u_sva (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
	.s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bready_in(s_axi_bready_in), .s_axi_rdata_out(s_axi_rdata_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.serial_clock_pin_in(serial_clock_pin_in), .serial_out_pin_oe_out(serial_out_pin_oe_out),
	.bus_data_pin_a_out(bus_data_pin_a_out), .bus_data_pin_a_oe_out(bus_data_pin_a_oe_out),
	.transfer_irq_out(transfer_irq_out));
